/* src/obh_loader.v */
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
`include "obh_defines.vh"

// Functional notes
// - Development mode maps address zero to download RAM; processor runs from there.
// - Normal mode copies array code into system RAM on boot and wake.
// - Array addressed as 8K words of 32 bits.
// - Single-byte fields replicated in all four bytes, written and compared.
// - Debug word 0x00 keeps debug port active, 0xAA disables it.
// - Copy-length word gives number of 32-bit words copied.
// - Signature selector: 0x00 none, 0xAA MD5, 0x55 SHA-1, 0xFF CRC32.
// - Trim values fetched from their fixed header words.
// - Calibration upper half 0xA5A5 means calibrated, 0x0000 means not.
// - Calibration bits five to zero mark each trim value valid.
// - Sleep clock word 0x00 slow crystal, 0xAA precision RC.
// - Package word 0x00 chip-scale, 0xAA forty-pin, 0x55 forty-eight-pin.
// - Trim check word sits just above IQ trim word.
// - Application present only when both programmed flags hold their codes.
// - Both flags matching selects normal mode, otherwise development mode.
// - Unprogrammed array reads zero, so every flag reads zero.
module obh_loader #(
    parameter AW        = 13,
    parameter DW        = 32,
    parameter OTP_WORDS = `OBH_OTP_WORDS
) (
    // Clock and reset
    input  wire          CLOCK,
    input  wire          RESET,
    // Register port
    input  wire [14:0]   ADDR,
    input  wire [31:0]   WDATA,
    input  wire          WR,
    input  wire          RD,
    output reg  [31:0]   RDATA,
    // Wake-up request
    input  wire          WAKE,
    // Array read port
    output reg  [AW-1:0] OTP_ADDR,
    output reg           OTP_RD,
    input  wire [DW-1:0] OTP_RDATA,
    // System RAM write port
    output reg  [AW-1:0] RAM_ADDR,
    output reg  [DW-1:0] RAM_WDATA,
    output reg           RAM_WE,
    // Processor control
    output reg           CPU_RESET,
    output reg           REMAP_ZERO,
    output reg           MODE_NORMAL,
    output reg           BOOT_DONE,
    // Decoded configuration
    output reg           DEBUG_PORT_EN,
    output reg  [1:0]    SIG_SEL,
    output reg           CAL_DONE,
    output reg  [5:0]    TRIM_VALID,
    output reg           SLEEP_CLK_RC,
    output reg  [1:0]    PACKAGE_SEL,
    output reg  [AW:0]   COPY_WORDS
);

    localparam [1:0] ST_FETCH  = 2'd0;
    localparam [1:0] ST_DECODE = 2'd1;
    localparam [1:0] ST_COPY   = 2'd2;
    localparam [1:0] ST_RUN    = 2'd3;

    localparam [AW:0] MAX_WORDS = OTP_WORDS;

    // Signature selector codes
    localparam [1:0] SIG_NONE  = 2'h0;
    localparam [1:0] SIG_MD5   = 2'h1;
    localparam [1:0] SIG_SHA1  = 2'h2;
    localparam [1:0] SIG_CRC32 = 2'h3;

    // Package variant codes
    localparam [1:0] PKG_CHIP_SCALE  = 2'h0;
    localparam [1:0] PKG_FORTY       = 2'h1;
    localparam [1:0] PKG_FORTY_EIGHT = 2'h2;

    reg [1:0]    state_q;
    reg [4:0]    idx_q;
    reg [4:0]    iss_idx_q;
    reg          cap_q;
    reg [4:0]    cap_idx_q;
    reg [AW-1:0] cap_addr_q;
    reg [AW:0]   cnt_q;
    reg          hold_q;
    reg          wake_q;
    reg [DW-1:0] hdr_q [0:16];

    reg [31:0]   rd_d;
    reg [AW:0]   len_d;
    reg          app_d;
    reg          cal_d;
    integer      i;
    reg          dbg_off_d;
    reg [1:0]    sig_d;
    reg          slp_d;
    reg [1:0]    pkg_d;
    wire [14:0]  fetch_off;
    wire [16:0]  hdr_hit;
    wire [5:0]   tv_d;
    wire [31:0]  status_w;

    // Offset of each fetched header word
    function [14:0] hdr_off;
        input [4:0] n;
        begin
            case (n)
                5'd0:    hdr_off = `OBH_OFF_FLAG_ONE;
                5'd1:    hdr_off = `OBH_OFF_FLAG_TWO;
                5'd2:    hdr_off = `OBH_OFF_IQ_TRIM;
                5'd3:    hdr_off = `OBH_OFF_TRIM_CHECK;
                5'd4:    hdr_off = `OBH_OFF_PACKAGE;
                5'd5:    hdr_off = `OBH_OFF_SLEEP_CLK;
                5'd6:    hdr_off = `OBH_OFF_CAL_STATUS;
                5'd7:    hdr_off = `OBH_OFF_LNA_TRIM;
                5'd8:    hdr_off = `OBH_OFF_ANT_TRIM;
                5'd9:    hdr_off = `OBH_OFF_BG_TRIM;
                5'd10:   hdr_off = `OBH_OFF_RC_TRIM;
                5'd11:   hdr_off = `OBH_OFF_XTAL_TRIM;
                5'd12:   hdr_off = `OBH_OFF_VCO_TRIM;
                5'd13:   hdr_off = `OBH_OFF_SIG_SEL;
                5'd14:   hdr_off = `OBH_OFF_RSVD_ZERO;
                5'd15:   hdr_off = `OBH_OFF_COPY_LEN;
                default: hdr_off = `OBH_OFF_DEBUG_EN;
            endcase
        end
    endfunction

    // Byte replicated in all four lanes
    function rep;
        input [31:0] w;
        input [7:0]  b;
        begin
            rep = (w == {4{b}});
        end
    endfunction

    // Fetch offset, word address taken from its upper bits
    assign fetch_off = hdr_off(idx_q);

    // Header copies and read match, one per entry
    genvar g;
    generate
        for (g = 0; g < 17; g = g + 1) begin : g_hdr
            localparam [4:0] IDX = g;
            assign hdr_hit[g] = (ADDR == hdr_off(IDX));

            always @(posedge CLOCK) begin
                if (RESET) begin
                    hdr_q[g] <= {DW{1'b0}};
                end else if (state_q == ST_FETCH && cap_q && cap_idx_q == IDX) begin
                    hdr_q[g] <= OTP_RDATA;
                end
            end
        end
    endgenerate

    // Trim valid bits, each gated by the marker
    generate
        for (g = 0; g < 6; g = g + 1) begin : g_tv
            assign tv_d[g] = cal_d & hdr_q[`OBH_IDX_CAL_STATUS][g];
        end
    endgenerate

    // Status word, spare bits read zero
    assign status_w[0]     = BOOT_DONE;
    assign status_w[1]     = MODE_NORMAL;
    assign status_w[2]     = REMAP_ZERO;
    assign status_w[3]     = DEBUG_PORT_EN;
    assign status_w[5:4]   = SIG_SEL;
    assign status_w[6]     = CAL_DONE;
    assign status_w[12:7]  = TRIM_VALID;
    assign status_w[13]    = SLEEP_CLK_RC;
    assign status_w[15:14] = PACKAGE_SEL;
    assign status_w[17:16] = state_q;
    assign status_w[31:18] = 14'h0;

    // Decode helpers
    always @* begin
        app_d = (hdr_q[`OBH_IDX_FLAG_TWO] == `OBH_APP_TWO_CODE) &&
                (hdr_q[`OBH_IDX_FLAG_ONE] == `OBH_APP_ONE_CODE);
        cal_d = (hdr_q[`OBH_IDX_CAL_STATUS][31:16] == `OBH_CAL_DONE_CODE);
        // copy length, clipped to the array
        if (hdr_q[`OBH_IDX_COPY_LEN] > OTP_WORDS) begin
            len_d = MAX_WORDS;
        end else begin
            len_d = hdr_q[`OBH_IDX_COPY_LEN][AW:0];
        end
    end

    // Single-byte fields, any unlisted value is the default
    always @* begin
        // only the disable code turns the port off
        dbg_off_d = rep(hdr_q[`OBH_IDX_DEBUG_EN], `OBH_BYTE_AA);
        if (rep(hdr_q[`OBH_IDX_SIG_SEL], `OBH_BYTE_AA)) begin
            sig_d = SIG_MD5;
        end else if (rep(hdr_q[`OBH_IDX_SIG_SEL], `OBH_BYTE_55)) begin
            sig_d = SIG_SHA1;
        end else if (rep(hdr_q[`OBH_IDX_SIG_SEL], `OBH_BYTE_FF)) begin
            sig_d = SIG_CRC32;
        end else begin
            sig_d = SIG_NONE;
        end
        // RC only on its exact code
        slp_d = rep(hdr_q[`OBH_IDX_SLEEP_CLK], `OBH_BYTE_AA);
        if (rep(hdr_q[`OBH_IDX_PACKAGE], `OBH_BYTE_AA)) begin
            pkg_d = PKG_FORTY;
        end else if (rep(hdr_q[`OBH_IDX_PACKAGE], `OBH_BYTE_55)) begin
            pkg_d = PKG_FORTY_EIGHT;
        end else begin
            // unknown code falls back to default
            pkg_d = PKG_CHIP_SCALE;
        end
    end

    // Register read mux
    always @* begin
        rd_d = 32'h0;
        if (ADDR == `OBH_OFF_STATUS) begin
            rd_d = status_w;
        end else if (ADDR == `OBH_OFF_CONTROL) begin
            rd_d = {30'h0, hold_q, 1'b0};
        end else begin
            for (i = 0; i < 17; i = i + 1) begin
                if (hdr_hit[i]) begin
                    rd_d = hdr_q[i];
                end
            end
        end
    end

    // Register port, data valid only the cycle after a read
    always @(posedge CLOCK) begin
        if (RESET) begin
            RDATA  <= 32'h0;
            hold_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            // Zero between answers, so a late sample shows up
            RDATA  <= RD ? rd_d : 32'h0;
            wake_q <= 1'b0;
            if (WR && ADDR == `OBH_OFF_CONTROL) begin
                hold_q <= WDATA[`OBH_CTL_HOLD];
                wake_q <= WDATA[`OBH_CTL_WAKE];
            end
        end
    end

    // Boot sequencer
    always @(posedge CLOCK) begin
        if (RESET) begin
            state_q       <= ST_FETCH;
            idx_q         <= 5'd0;
            iss_idx_q     <= 5'd0;
            cap_q         <= 1'b0;
            cap_idx_q     <= 5'd0;
            cap_addr_q    <= {AW{1'b0}};
            cnt_q         <= {(AW+1){1'b0}};
            OTP_ADDR      <= {AW{1'b0}};
            OTP_RD        <= 1'b0;
            RAM_ADDR      <= {AW{1'b0}};
            RAM_WDATA     <= {DW{1'b0}};
            RAM_WE        <= 1'b0;
            CPU_RESET     <= 1'b1;
            REMAP_ZERO    <= 1'b0;
            MODE_NORMAL   <= 1'b0;
            BOOT_DONE     <= 1'b0;
        end else begin
            OTP_RD <= 1'b0;
            RAM_WE <= 1'b0;
            cap_q  <= OTP_RD;
            cap_idx_q  <= iss_idx_q;
            cap_addr_q <= OTP_ADDR;
            case (state_q)
                ST_FETCH: begin
                    // header words read from fixed addresses
                    if (idx_q < `OBH_NUM_HDR) begin
                        // word address into 8K x 32 array
                        OTP_ADDR  <= fetch_off[AW+1:2];
                        OTP_RD    <= 1'b1;
                        iss_idx_q <= idx_q;
                        idx_q     <= idx_q + 5'd1;
                    end else if (!OTP_RD && !cap_q) begin
                        // Drain the last read before decoding
                        state_q <= ST_DECODE;
                    end
                end

                ST_DECODE: begin
                    cnt_q      <= {(AW+1){1'b0}};
                    if (app_d) begin
                        MODE_NORMAL <= 1'b1;
                        REMAP_ZERO  <= 1'b0;
                        state_q     <= ST_COPY;
                    end else begin
                        // address zero points at download RAM
                        MODE_NORMAL <= 1'b0;
                        REMAP_ZERO  <= 1'b1;
                        BOOT_DONE   <= 1'b1;
                        state_q     <= ST_RUN;
                    end
                end

                ST_COPY: begin
                    if (cnt_q < COPY_WORDS) begin
                        OTP_ADDR <= cnt_q[AW-1:0];
                        OTP_RD   <= 1'b1;
                        cnt_q    <= cnt_q + 1'b1;
                    end else if (!OTP_RD && !cap_q) begin
                        // Last word lands two cycles after its read
                        BOOT_DONE <= 1'b1;
                        state_q   <= ST_RUN;
                    end
                    if (cap_q) begin
                        RAM_ADDR  <= cap_addr_q;
                        RAM_WDATA <= OTP_RDATA;
                        RAM_WE    <= 1'b1;
                    end
                end

                default: begin
                    // processor leaves reset and runs
                    // Hold bit parks the processor for a debugger
                    CPU_RESET <= hold_q;
                    // wake-up repeats the copy with the kept length
                    if (MODE_NORMAL && (WAKE || wake_q)) begin
                        CPU_RESET <= 1'b1;
                        BOOT_DONE <= 1'b0;
                        cnt_q     <= {(AW+1){1'b0}};
                        state_q   <= ST_COPY;
                    end
                end
            endcase
        end
    end

    // Decoded configuration, taken once per boot
    always @(posedge CLOCK) begin
        if (RESET) begin
            DEBUG_PORT_EN <= 1'b1;
            SIG_SEL       <= SIG_NONE;
            CAL_DONE      <= 1'b0;
            TRIM_VALID    <= 6'h0;
            SLEEP_CLK_RC  <= 1'b0;
            PACKAGE_SEL   <= PKG_CHIP_SCALE;
            COPY_WORDS    <= {(AW+1){1'b0}};
        end else if (state_q == ST_DECODE) begin
            DEBUG_PORT_EN <= !dbg_off_d;
            SIG_SEL       <= sig_d;
            CAL_DONE      <= cal_d;
            TRIM_VALID    <= tv_d;
            SLEEP_CLK_RC  <= slp_d;
            PACKAGE_SEL   <= pkg_d;
            COPY_WORDS    <= len_d;
        end
    end

endmodule // obh_loader

/* src/obh_defines.vh */
`ifndef OBH_DEFINES_VH
`define OBH_DEFINES_VH

// Header byte offsets
`define OBH_OFF_FLAG_ONE    15'h7f00
`define OBH_OFF_FLAG_TWO    15'h7f04
`define OBH_OFF_IQ_TRIM     15'h7f08
`define OBH_OFF_TRIM_CHECK  15'h7f0c
`define OBH_OFF_PACKAGE     15'h7f70
`define OBH_OFF_SLEEP_CLK   15'h7f74
`define OBH_OFF_CAL_STATUS  15'h7f78
`define OBH_OFF_LNA_TRIM    15'h7f7c
`define OBH_OFF_ANT_TRIM    15'h7f80
`define OBH_OFF_BG_TRIM     15'h7f84
`define OBH_OFF_RC_TRIM     15'h7f88
`define OBH_OFF_XTAL_TRIM   15'h7f8c
`define OBH_OFF_VCO_TRIM    15'h7f90
`define OBH_OFF_SIG_SEL     15'h7fd0
`define OBH_OFF_RSVD_ZERO   15'h7ff4
`define OBH_OFF_COPY_LEN    15'h7ff8
`define OBH_OFF_DEBUG_EN    15'h7ffc

// Own control and status registers
`define OBH_OFF_STATUS      15'h7e00
`define OBH_OFF_CONTROL     15'h7e04

// Header entry indices, ascending offset
`define OBH_NUM_HDR         5'd17
`define OBH_IDX_FLAG_ONE    5'd0
`define OBH_IDX_FLAG_TWO    5'd1
`define OBH_IDX_PACKAGE     5'd4
`define OBH_IDX_SLEEP_CLK   5'd5
`define OBH_IDX_CAL_STATUS  5'd6
`define OBH_IDX_SIG_SEL     5'd13
`define OBH_IDX_COPY_LEN    5'd15
`define OBH_IDX_DEBUG_EN    5'd16

// Flag encodings
`define OBH_BYTE_ZERO       8'h00
`define OBH_BYTE_AA         8'haa
`define OBH_BYTE_55         8'h55
`define OBH_BYTE_FF         8'hff
`define OBH_CAL_DONE_CODE   16'ha5a5
`define OBH_CAL_NONE_CODE   16'h0000
`define OBH_APP_TWO_CODE    32'ha5a51234
`define OBH_APP_ONE_CODE    32'h1234a5a5

// Array geometry and control bits
`define OBH_OTP_WORDS       8192
`define OBH_CTL_WAKE        0
`define OBH_CTL_HOLD        1

`endif

/* tb/obh_otp_model.sv */
`timescale 1ns/100ps
module obh_otp_model (
    // Clock
    input  wire         clock,
    // Array read port
    input  wire  [12:0] addr,
    input  wire         rd,
    output logic [31:0] rdata = 32'h0
);
    // array of 8K words, blank reads zero
    logic [31:0] mem [0:8191];

    // Idle cycles invert the held word every cycle
    always @(posedge clock) begin
        if (rd) begin
            rdata <= mem[addr];
        end else begin
            rdata <= ~rdata;
        end
    end
endmodule // obh_otp_model

/* tb/obh_loader_sva.sv */
`timescale 1ns/100ps
module obh_loader_sva #(
    parameter AW        = 13,
    parameter DW        = 32,
    parameter OTP_WORDS = 8192
) (
    // Clock and reset
    input wire          CLOCK,
    input wire          RESET,
    // Register port
    input wire [14:0]   ADDR,
    input wire [31:0]   WDATA,
    input wire          WR,
    input wire          RD,
    input wire [31:0]   RDATA,
    input wire          WAKE,
    // Array and RAM
    input wire [AW-1:0] OTP_ADDR,
    input wire          OTP_RD,
    input wire [DW-1:0] OTP_RDATA,
    input wire [AW-1:0] RAM_ADDR,
    input wire [DW-1:0] RAM_WDATA,
    input wire          RAM_WE,
    // Control and decode
    input wire          CPU_RESET,
    input wire          REMAP_ZERO,
    input wire          MODE_NORMAL,
    input wire          BOOT_DONE,
    input wire          DEBUG_PORT_EN,
    input wire [1:0]    SIG_SEL,
    input wire          CAL_DONE,
    input wire [5:0]    TRIM_VALID,
    input wire          SLEEP_CLK_RC,
    input wire [1:0]    PACKAGE_SEL,
    input wire [AW:0]   COPY_WORDS
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);

    rdata_idle_a: assert property (!$past(RD) |-> RDATA == 32'h0) else $error("read data outside answer");
    fetch_start_a: assert property ($past(RESET) && !RESET |=> OTP_RD && OTP_ADDR == 13'h1fc0)
        else $error("fetch start wrong");
    fetch_order_a: assert property (MODE_NORMAL && OTP_RD && $past(OTP_RD) && OTP_ADDR != 0 |->
        OTP_ADDR == $past(OTP_ADDR) + 1) else $error("array reads not ascending");
    ram_follow_a: assert property (RAM_WE |-> RAM_ADDR == $past(OTP_ADDR, 2) &&
        RAM_WDATA == $past(OTP_RDATA)) else $error("copy word mismatch");
    copy_bound_a: assert property (RAM_WE |-> {1'b0, RAM_ADDR} < COPY_WORDS) else $error("copy overrun");
    normal_copy_a: assert property (RAM_WE |-> MODE_NORMAL) else $error("copy outside normal mode");
    mode_remap_a: assert property (BOOT_DONE |-> REMAP_ZERO == !MODE_NORMAL) else $error("remap wrong");
    cal_gate_a: assert property (!CAL_DONE |-> TRIM_VALID == 6'h0) else $error("trim valid uncalibrated");
    wake_copy_a: assert property (WAKE && BOOT_DONE && MODE_NORMAL |-> ##[1:2] (CPU_RESET && !BOOT_DONE))
        else $error("wake ignored");
endmodule // obh_loader_sva

bind obh_loader obh_loader_sva #(.AW(AW), .DW(DW), .OTP_WORDS(OTP_WORDS)) chk (.CLOCK(CLOCK), .RESET(RESET),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .WAKE(WAKE), .OTP_ADDR(OTP_ADDR),
    .OTP_RD(OTP_RD), .OTP_RDATA(OTP_RDATA), .RAM_ADDR(RAM_ADDR), .RAM_WDATA(RAM_WDATA), .RAM_WE(RAM_WE),
    .CPU_RESET(CPU_RESET), .REMAP_ZERO(REMAP_ZERO), .MODE_NORMAL(MODE_NORMAL), .BOOT_DONE(BOOT_DONE),
    .DEBUG_PORT_EN(DEBUG_PORT_EN), .SIG_SEL(SIG_SEL), .CAL_DONE(CAL_DONE), .TRIM_VALID(TRIM_VALID),
    .SLEEP_CLK_RC(SLEEP_CLK_RC), .PACKAGE_SEL(PACKAGE_SEL), .COPY_WORDS(COPY_WORDS));

/* tb/obh_loader_tb.sv */
`timescale 1ns/100ps
module obh_loader_tb;
    logic        clock = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0, wake = 1'b0;
    logic [14:0] addr = 15'h0;
    logic [31:0] wdata = 32'h0, rdata, otp_rdata, ram_wdata, d;
    logic [12:0] otp_addr, ram_addr;
    logic        otp_rd, ram_we, cpu_reset, remap, normal, done, dbg, cal, slp;
    logic [1:0]  sig, pkg;
    logic [5:0]  tv;
    logic [13:0] copy_words;
    int          mismatches = 0, checked = 0, writes = 0;
    // Cases: replicated codes, one unreplicated byte, swapped and lone flags
    logic [31:0] code_w [5] = '{32'h0, 32'haaaaaaaa, 32'h55555555, 32'hffffffff, 32'h000000aa};
    logic [31:0] cal_w [5] = '{32'h0, 32'ha5a5003f, 32'ha5a50012, 32'h0000003f, 32'h12340001};
    logic [31:0] f1_w [5] = '{32'h0, 32'h1234a5a5, 32'h1234a5a5, 32'ha5a51234, 32'h1234a5a5};
    logic [31:0] f2_w [5] = '{32'h0, 32'ha5a51234, 32'ha5a51234, 32'h1234a5a5, 32'h0};
    int          len [5] = '{5, 3, 0, 2, 0}, e_dbg [5] = '{1, 0, 1, 1, 1}, e_sig [5] = '{0, 1, 2, 3, 0};
    int          e_slp [5] = '{0, 1, 0, 0, 0}, e_pkg [5] = '{0, 1, 2, 0, 0}, e_cal [5] = '{0, 1, 1, 0, 0};
    int          e_tv [5] = '{0, 63, 18, 0, 0}, e_nrm [5] = '{0, 1, 1, 0, 0};

    always #5 clock = ~clock;

    obh_loader dut (.CLOCK(clock), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .WAKE(wake), .OTP_ADDR(otp_addr), .OTP_RD(otp_rd), .OTP_RDATA(otp_rdata), .RAM_ADDR(ram_addr),
        .RAM_WDATA(ram_wdata), .RAM_WE(ram_we), .CPU_RESET(cpu_reset), .REMAP_ZERO(remap),
        .MODE_NORMAL(normal), .BOOT_DONE(done), .DEBUG_PORT_EN(dbg), .SIG_SEL(sig), .CAL_DONE(cal),
        .TRIM_VALID(tv), .SLEEP_CLK_RC(slp), .PACKAGE_SEL(pkg), .COPY_WORDS(copy_words));
    obh_otp_model otp (.clock(clock), .addr(otp_addr), .rd(otp_rd), .rdata(otp_rdata));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task wrap_up;
        if (mismatches == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task reg_rd(input logic [14:0] a, output logic [31:0] v);
        @(posedge clock) rd <= 1'b1;
        addr <= a;
        @(posedge clock) rd <= 1'b0;
        #1 v = rdata;
    endtask

    task reg_wr(input logic [14:0] a, input logic [31:0] v);
        @(posedge clock) wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clock) wr <= 1'b0;
    endtask

    task wait_done;
        for (int n = 0; n < 300 && done !== 1'b1; n++) begin
            @(posedge clock);
            #1;
        end
        check("boot_done", done, 1);
    endtask

    always @(posedge clock) if (!reset && ram_we === 1'b1) begin
        writes++;
        check("ram_data", ram_wdata, otp.mem[ram_addr]);
    end

    task automatic run(input int e);
        logic [31:0] st;
        st = 1 | e_nrm[e] << 1 | (1 - e_nrm[e]) << 2 | e_dbg[e] << 3 | e_sig[e] << 4 | e_cal[e] << 6;
        st = st | e_tv[e] << 7 | e_slp[e] << 13 | e_pkg[e] << 14 | 3 << 16;
        // single-byte codes written in all four bytes, except the lone byte of case 4
        otp.mem[13'h1fff] = code_w[e];
        otp.mem[13'h1ff4] = code_w[e];
        otp.mem[13'h1fdd] = code_w[e];
        otp.mem[13'h1fdc] = code_w[e];
        otp.mem[13'h1fde] = cal_w[e];
        otp.mem[13'h1ffe] = len[e];
        otp.mem[13'h1fc0] = f1_w[e];
        otp.mem[13'h1fc1] = f2_w[e];
        otp.mem[13'h1fc3] = 32'h7e1c0c0c + e;
        writes = 0;
        @(posedge clock) reset <= 1'b1;
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        wait_done();
        check("normal", normal, e_nrm[e]);
        check("remap", remap, 1 - e_nrm[e]);
        check("debug_en", dbg, e_dbg[e]);
        check("sig_sel", sig, e_sig[e]);
        check("cal_done", cal, e_cal[e]);
        check("trim_valid", tv, e_tv[e]);
        check("sleep_rc", slp, e_slp[e]);
        check("package", pkg, e_pkg[e]);
        reg_rd(15'h7e00, d);
        check("status", d, st);
        reg_wr(15'h7fd0, 32'h1);
        reg_rd(15'h7fd0, d);
        check("sig_word", d, code_w[e]);
        reg_rd(15'h7f90, d);
        check("vco_trim", d, 32'h70001fe4);
        reg_rd(15'h7f0c, d);
        check("trim_check", d, 32'h7e1c0c0c + e);
        reg_rd(15'h7ff4, d);
        check("rsvd_word", d, 32'h0);
        check("copy_words", copy_words, len[e]);
        reg_rd(15'h0004, d);
        check("unmapped", d, 32'h0);
        check("cpu_reset", cpu_reset, 0);
        // Odd cases wake by pin, even ones by control bit
        if (e % 2) begin
            @(posedge clock) wake <= 1'b1;
            @(posedge clock) wake <= 1'b0;
        end else reg_wr(15'h7e04, 32'h1);
        repeat (3) @(posedge clock);
        wait_done();
        check("ram_writes", writes, 2 * e_nrm[e] * len[e]);
    endtask

    initial begin
        // vectors and code from zero, one blank word, then a patch
        for (int i = 0; i < 8192; i++) otp.mem[i] = (i < 96) ? 32'hc0de0000 + i : 32'h0;
        otp.mem[97] = 32'h9a7c0001;
        for (int i = 13'h1fdf; i < 13'h1fe5; i++) otp.mem[i] = 32'h70000000 + i;
        // reserved zero, radio address bytes ascending, signature
        otp.mem[13'h1ffd] = 32'h0;
        otp.mem[13'h1ff5] = 32'h44332211;
        otp.mem[13'h1ff6] = 32'h00006655;
        for (int i = 13'h1fe5; i < 13'h1ff4; i++) otp.mem[i] = 32'h5a000000 + i;
        for (int e = 0; e < 5; e++) run(e);
        wrap_up();
    end

    // Whole run is a few hundred cycles
    initial begin
        #100000;
        mismatches++;
        wrap_up();
    end
endmodule // obh_loader_tb
